/* File: hw/pp_exec_pkg.sv */
// constants, opcodes and widths for the peripheral-processor execute unit, opcodes 20 to 51
// Function
// - opcode 20 clears accumulator, loads d as upper six, next word lower twelve
// - add-constant adds eighteen-bit d/next-word constant to the accumulator
// - logical-product-constant ANDs accumulator with the d/next-word constant
// - opcode 23 inverts accumulator bits where the d/next-word constant has ones
// - load relocation from d (low ten) and d+1 (next twelve); d zero passes
// - store relocation to d (low ten) and d+1 (next twelve); d zero passes
// - plain exchange keeps monitor flag; address R+A if A sign set; stall
// - monitor exchanges pass in monitor mode, else exchange setting monitor flag
// - monitor-address variant takes package address from outgoing package field
// - keypoint changes no state but pulses a test point once
// - opcode 30 loads word at d, upper six accumulator bits zero
// - direct add and subtract use word at d as positive twelve-bit value
// - direct xor flips low twelve bits by word at d, upper six kept
// - direct store writes low twelve accumulator bits to location d
// - opcode 35 adds word at d, writes low twelve back, keeps sum
// - opcodes 36/37 increment or decrement word at d; result replaces accumulator
// - indirect load uses word at d as address, loads operand zero-extended
// - indirect add and subtract use positive operand at address held in d
// - opcode 43 xors low twelve bits with indirect operand, upper six kept
// - opcode 44 stores low twelve accumulator bits at address held in d
// - indirect replace ops write low twelve result back, keep result in accumulator
// - indexed ops use next word plus (d) when d nonzero; loads zero upper bits
// - all-ones accumulator is negative zero: nonzero and negative
`default_nettype none
package pp_exec_pkg;
  localparam int ACC_W  = 18;
  localparam int WORD_W = 12;
  localparam int D_W    = 6;
  localparam int OP_W   = 6;
  localparam int R_LO_W = 10;
  localparam int R_HI_W = 12;
  localparam int R_W    = R_LO_W + R_HI_W;
  localparam int R_SHIFT = 6;
  localparam int CM_W   = R_W + R_SHIFT;
  localparam int SIGN_BIT = ACC_W - 1;

  localparam logic [ACC_W-1:0] ACC_NEG_ZERO = 18'h3FFFF;
  localparam logic [ACC_W-1:0] ACC_PLUS_ONE = 18'h00001;
  localparam logic [ACC_W-1:0] ACC_MINUS_ONE = 18'h3FFFE;
  localparam logic [D_W-1:0]   D_ZERO = 6'h00;
  localparam logic [R_SHIFT-1:0] R_PAD = 6'h00;

  // opcodes, octal 20..51 written in hex
  localparam logic [OP_W-1:0] OP_LOAD_CONSTANT = 6'h10;
  localparam logic [OP_W-1:0] OP_ADD_CONSTANT  = 6'h11;
  localparam logic [OP_W-1:0] OP_AND_CONSTANT  = 6'h12;
  localparam logic [OP_W-1:0] OP_XOR_CONSTANT  = 6'h13;
  localparam logic [OP_W-1:0] OP_LOAD_RELOC    = 6'h14;
  localparam logic [OP_W-1:0] OP_STORE_RELOC   = 6'h15;
  localparam logic [OP_W-1:0] OP_EXCHANGE      = 6'h16;
  localparam logic [OP_W-1:0] OP_KEYPOINT      = 6'h17;
  localparam logic [OP_W-1:0] OP_DIRECT_FIRST  = 6'h18;
  localparam logic [OP_W-1:0] OP_INDIRECT_FIRST = 6'h20;
  localparam logic [OP_W-1:0] OP_INDIRECT_LAST = 6'h27;
  localparam logic [OP_W-1:0] OP_LOAD_INDEXED  = 6'h28;
  localparam logic [OP_W-1:0] OP_ADD_INDEXED   = 6'h29;

  // exchange variants carried in the d field of opcode 26
  localparam logic [D_W-1:0] D_EXCHANGE_UNCONDITIONAL = 6'h00;
  localparam logic [D_W-1:0] D_EXCHANGE_MONITOR       = 6'h08;
  localparam logic [D_W-1:0] D_EXCHANGE_TO_MONITOR_ADDRESS = 6'h10;

  // memory sub-operation held in the low three opcode bits of groups 3x, 4x, 5x
  typedef enum logic [2:0] {
    SUB_LOAD    = 3'h0,
    SUB_ADD     = 3'h1,
    SUB_SUB     = 3'h2,
    SUB_XOR     = 3'h3,
    SUB_STORE   = 3'h4,
    SUB_REPLACE = 3'h5,
    SUB_INC     = 3'h6,
    SUB_DEC     = 3'h7
  } sub_op_t;

  typedef enum logic [2:0] {
    S_IDLE     = 3'h0,
    S_WAIT_M   = 3'h1,
    S_WAIT_D   = 3'h2,
    S_WAIT_D1  = 3'h3,
    S_WAIT_OP  = 3'h4,
    S_WRITE_HI = 3'h5,
    S_XCHG     = 3'h6,
    S_XCHG_END = 3'h7
  } state_t;
endpackage
`default_nettype wire

/* File: hw/ones_add18.sv */
// eighteen-bit ones' complement adder with end-around carry
`default_nettype none
module ones_add18
  import pp_exec_pkg::*;
(
  input  wire logic [ACC_W-1:0] a,
  input  wire logic [ACC_W-1:0] b,
  output logic      [ACC_W-1:0] sum
);
  logic [ACC_W:0] raw;

  // carry out of the top folds back into bit 0
  always_comb begin
    raw = {1'b0, a} + {1'b0, b};
    sum = raw[ACC_W-1:0] + {{(ACC_W-1){1'b0}}, raw[ACC_W]};
  end
endmodule // ones_add18
`default_nettype wire

/* File: hw/pp_exec.sv */
// execute unit for peripheral-processor opcodes 20 through 51
`default_nettype none
module pp_exec
  import pp_exec_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic              start,
  input  wire logic [OP_W-1:0]   opcode,
  input  wire logic [D_W-1:0]    d_field,
  input  wire logic [WORD_W-1:0] p_addr,
  input  wire logic [WORD_W-1:0] mem_rdata,
  input  wire logic              cp_monitor_mode,
  input  wire logic              xchg_done,
  output logic                   busy,
  output logic                   done,
  output logic [ACC_W-1:0]       acc,
  output logic [R_W-1:0]         r_reg,
  output logic                   acc_zero,
  output logic                   acc_negative,
  output logic [WORD_W-1:0]      mem_addr,
  output logic                   mem_rd,
  output logic                   mem_wr,
  output logic [WORD_W-1:0]      mem_wdata,
  output logic                   xchg_req,
  output logic [CM_W-1:0]        xchg_addr,
  output logic                   xchg_set_monitor,
  output logic                   xchg_use_ma,
  output logic                   keypoint
);

  // zero-extend a memory word into an accumulator-wide value
  function automatic logic [ACC_W-1:0] zext(input logic [WORD_W-1:0] w);
    return {{(ACC_W-WORD_W){1'b0}}, w};
  endfunction

  // widen a d field into a memory address
  function automatic logic [WORD_W-1:0] d_addr(input logic [D_W-1:0] dv);
    return {{(WORD_W-D_W){1'b0}}, dv};
  endfunction

  // accumulator result of a memory sub-operation
  function automatic logic [ACC_W-1:0] apply_sub(
    input sub_op_t          s,
    input logic [ACC_W-1:0] a,
    input logic [WORD_W-1:0] w,
    input logic [ACC_W-1:0] sum
  );
    logic [ACC_W-1:0] r;
    r = a;
    unique case (s)
      SUB_LOAD:  r = zext(w);
      SUB_XOR:   r = {a[ACC_W-1:WORD_W], a[WORD_W-1:0] ^ w};
      SUB_STORE: r = a;
      SUB_ADD, SUB_SUB, SUB_REPLACE, SUB_INC, SUB_DEC: r = sum;
    endcase
    return r;
  endfunction

  // sub-operations that write their low bits back to the operand
  function automatic logic sub_writes(input sub_op_t s);
    return (s == SUB_STORE) || (s == SUB_REPLACE) || (s == SUB_INC) || (s == SUB_DEC);
  endfunction

  // two-flop synchronisers for the processor-side levels
  logic mon_meta;
  logic mon_sync;
  logic done_meta;
  logic done_sync;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mon_meta  <= 1'b0;
      mon_sync  <= 1'b0;
      done_meta <= 1'b0;
      done_sync <= 1'b0;
    end else begin
      mon_meta  <= cp_monitor_mode;
      mon_sync  <= mon_meta;
      done_meta <= xchg_done;
      done_sync <= done_meta;
    end
  end

  // latched instruction and scratch state
  state_t            state;
  logic [OP_W-1:0]   op;
  logic [D_W-1:0]    d;
  logic [WORD_W-1:0] m_word;
  logic [WORD_W-1:0] oper_addr;

  state_t            next_state;
  logic [OP_W-1:0]   next_op;
  logic [D_W-1:0]    next_d;
  logic [WORD_W-1:0] next_m_word;
  logic [WORD_W-1:0] next_oper_addr;
  logic              next_busy;
  logic              next_done;
  logic [ACC_W-1:0]  next_acc;
  logic [R_W-1:0]    next_r_reg;
  logic [WORD_W-1:0] next_mem_addr;
  logic              next_mem_rd;
  logic              next_mem_wr;
  logic [WORD_W-1:0] next_mem_wdata;
  logic              next_xchg_req;
  logic [CM_W-1:0]   next_xchg_addr;
  logic              next_xchg_set_monitor;
  logic              next_xchg_use_ma;
  logic              next_keypoint;

  // single shared adder: operands steered by state and sub-operation
  logic [ACC_W-1:0] add_a;
  logic [ACC_W-1:0] add_b;
  logic [ACC_W-1:0] add_sum;
  sub_op_t          sub;

  always_comb begin
    sub   = sub_op_t'(op[2:0]);
    add_a = acc;
    add_b = zext(mem_rdata);
    if (state == S_WAIT_M) begin
      add_b = {d, mem_rdata};
    end else begin
      unique case (sub)
        SUB_SUB: add_b = ~zext(mem_rdata);
        SUB_INC: begin
          add_a = zext(mem_rdata);
          add_b = ACC_PLUS_ONE;
        end
        SUB_DEC: begin
          add_a = zext(mem_rdata);
          add_b = ACC_MINUS_ONE;
        end
        SUB_LOAD, SUB_ADD, SUB_XOR, SUB_STORE, SUB_REPLACE: add_b = zext(mem_rdata);
      endcase
    end
  end

  ones_add18 u_add (
    .a   (add_a),
    .b   (add_b),
    .sum (add_sum)
  );

  // sequencing: one memory access per cycle, read data arrives a cycle later
  always_comb begin
    next_state            = state;
    next_op               = op;
    next_d                = d;
    next_m_word           = m_word;
    next_oper_addr        = oper_addr;
    next_done             = 1'b0;
    next_acc              = acc;
    next_r_reg            = r_reg;
    next_mem_addr         = mem_addr;
    next_mem_rd           = 1'b0;
    next_mem_wr           = 1'b0;
    next_mem_wdata        = mem_wdata;
    next_xchg_req         = xchg_req;
    next_xchg_addr        = xchg_addr;
    next_xchg_set_monitor = xchg_set_monitor;
    next_xchg_use_ma      = xchg_use_ma;
    next_keypoint         = 1'b0;
    unique case (state)
      S_IDLE: begin
        if (start) begin
          next_op = opcode;
          next_d  = d_field;
          if ((opcode >= OP_LOAD_CONSTANT && opcode <= OP_XOR_CONSTANT) ||
              opcode == OP_LOAD_INDEXED || opcode == OP_ADD_INDEXED) begin
            // constant and indexed forms need the following program word
            next_mem_addr = p_addr + 12'h001;
            next_mem_rd   = 1'b1;
            next_state    = S_WAIT_M;
          end else if (opcode == OP_LOAD_RELOC || opcode == OP_STORE_RELOC) begin
            if (d_field == D_ZERO) begin
              next_done = 1'b1;
            end else if (opcode == OP_LOAD_RELOC) begin
              next_mem_addr = d_addr(d_field);
              next_mem_rd   = 1'b1;
              next_state    = S_WAIT_D;
            end else begin
              next_mem_addr  = d_addr(d_field);
              next_mem_wdata = zext10(r_reg[R_LO_W-1:0]);
              next_mem_wr    = 1'b1;
              next_state     = S_WRITE_HI;
            end
          end else if (opcode == OP_EXCHANGE) begin
            if (d_field == D_EXCHANGE_UNCONDITIONAL) begin
              next_xchg_req         = 1'b1;
              next_xchg_set_monitor = 1'b0;
              next_xchg_use_ma      = 1'b0;
              next_xchg_addr        = xchg_target(acc, r_reg);
              next_state            = S_XCHG;
            end else if ((d_field == D_EXCHANGE_MONITOR ||
                          d_field == D_EXCHANGE_TO_MONITOR_ADDRESS) && !mon_sync) begin
              next_xchg_req         = 1'b1;
              next_xchg_set_monitor = 1'b1;
              next_xchg_use_ma      = (d_field == D_EXCHANGE_TO_MONITOR_ADDRESS);
              next_xchg_addr        = xchg_target(acc, r_reg);
              next_state            = S_XCHG;
            end else begin
              next_done = 1'b1;
            end
          end else if (opcode == OP_KEYPOINT) begin
            next_keypoint = 1'b1;
            next_done     = 1'b1;
          end else if (opcode >= OP_DIRECT_FIRST && opcode <= OP_INDIRECT_LAST) begin
            next_mem_addr = d_addr(d_field);
            next_mem_rd   = 1'b1;
            next_state    = S_WAIT_D;
          end else begin
            next_done = 1'b1;                    // opcodes outside this unit finish at once
          end
        end
      end
      S_WAIT_M: begin
        next_m_word = mem_rdata;
        unique case (op)
          OP_LOAD_CONSTANT: begin
            next_acc  = {d, mem_rdata};
            next_done = 1'b1;
            next_state = S_IDLE;
          end
          OP_ADD_CONSTANT: begin
            next_acc  = add_sum;
            next_done = 1'b1;
            next_state = S_IDLE;
          end
          OP_AND_CONSTANT: begin
            next_acc  = acc & {d, mem_rdata};
            next_done = 1'b1;
            next_state = S_IDLE;
          end
          OP_XOR_CONSTANT: begin
            next_acc  = acc ^ {d, mem_rdata};
            next_done = 1'b1;
            next_state = S_IDLE;
          end
          default: begin
            // indexed: index from location d only when d is nonzero
            if (d == D_ZERO) begin
              next_oper_addr = mem_rdata;
              next_mem_addr  = mem_rdata;
              next_mem_rd    = 1'b1;
              next_state     = S_WAIT_OP;
            end else begin
              next_mem_addr = d_addr(d);
              next_mem_rd   = 1'b1;
              next_state    = S_WAIT_D;
            end
          end
        endcase
      end
      S_WAIT_D: begin
        if (op == OP_LOAD_RELOC) begin
          next_r_reg[R_LO_W-1:0] = mem_rdata[R_LO_W-1:0];
          next_mem_addr = d_addr(d) + 12'h001;
          next_mem_rd   = 1'b1;
          next_state    = S_WAIT_D1;
        end else if (op == OP_LOAD_INDEXED || op == OP_ADD_INDEXED) begin
          next_oper_addr = m_word + mem_rdata;
          next_mem_addr  = m_word + mem_rdata;
          next_mem_rd    = 1'b1;
          next_state     = S_WAIT_OP;
        end else if (op >= OP_INDIRECT_FIRST) begin
          next_oper_addr = mem_rdata;
          next_mem_addr  = mem_rdata;
          next_mem_rd    = 1'b1;
          next_state     = S_WAIT_OP;
        end else begin
          // direct group: word at d is the operand
          next_acc = apply_sub(sub, acc, mem_rdata, add_sum);
          if (sub_writes(sub)) begin
            next_mem_addr  = d_addr(d);
            next_mem_wdata = next_acc[WORD_W-1:0];
            next_mem_wr    = 1'b1;
          end
          next_done  = 1'b1;
          next_state = S_IDLE;
        end
      end
      S_WAIT_D1: begin
        next_r_reg[R_W-1:R_LO_W] = mem_rdata;
        next_done  = 1'b1;
        next_state = S_IDLE;
      end
      S_WAIT_OP: begin
        next_acc = apply_sub(sub, acc, mem_rdata, add_sum);
        if (sub_writes(sub)) begin
          next_mem_addr  = oper_addr;
          next_mem_wdata = next_acc[WORD_W-1:0];
          next_mem_wr    = 1'b1;
        end
        next_done  = 1'b1;
        next_state = S_IDLE;
      end
      S_WRITE_HI: begin
        next_mem_addr  = d_addr(d) + 12'h001;
        next_mem_wdata = r_reg[R_W-1:R_LO_W];
        next_mem_wr    = 1'b1;
        next_done      = 1'b1;
        next_state     = S_IDLE;
      end
      S_XCHG: begin
        // request held until the processor acknowledges; unit stalls meanwhile
        if (done_sync) begin
          next_xchg_req = 1'b0;
          next_state    = S_XCHG_END;
        end
      end
      S_XCHG_END: begin
        // four-phase close so a stale acknowledge cannot end the next exchange
        if (!done_sync) begin
          next_done  = 1'b1;
          next_state = S_IDLE;
        end
      end
    endcase
    next_busy = (next_state != S_IDLE);
  end

  // ten-bit relocation slice placed in a memory word
  function automatic logic [WORD_W-1:0] zext10(input logic [R_LO_W-1:0] v);
    return {{(WORD_W-R_LO_W){1'b0}}, v};
  endfunction

  // package address: relocated when the accumulator sign bit is set
  function automatic logic [CM_W-1:0] xchg_target(
    input logic [ACC_W-1:0] a,
    input logic [R_W-1:0]   r
  );
    logic [CM_W-1:0] t;
    if (a[SIGN_BIT]) begin
      t = {r, R_PAD} + {{(CM_W-SIGN_BIT){1'b0}}, a[SIGN_BIT-1:0]};
    end else begin
      t = {{(CM_W-ACC_W){1'b0}}, a};
    end
    return t;
  endfunction

  // register stage for all sequencing state and outputs
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state            <= S_IDLE;
      op               <= '0;
      d                <= '0;
      m_word           <= '0;
      oper_addr        <= '0;
      busy             <= 1'b0;
      done             <= 1'b0;
      acc              <= '0;
      r_reg            <= '0;
      acc_zero         <= 1'b1;
      acc_negative     <= 1'b0;
      mem_addr         <= '0;
      mem_rd           <= 1'b0;
      mem_wr           <= 1'b0;
      mem_wdata        <= '0;
      xchg_req         <= 1'b0;
      xchg_addr        <= '0;
      xchg_set_monitor <= 1'b0;
      xchg_use_ma      <= 1'b0;
      keypoint         <= 1'b0;
    end else begin
      state            <= next_state;
      op               <= next_op;
      d                <= next_d;
      m_word           <= next_m_word;
      oper_addr        <= next_oper_addr;
      busy             <= next_busy;
      done             <= next_done;
      acc              <= next_acc;
      r_reg            <= next_r_reg;
      acc_zero         <= (next_acc == '0);         // negative zero counts as nonzero
      acc_negative     <= next_acc[SIGN_BIT];       // all-ones reads negative
      mem_addr         <= next_mem_addr;
      mem_rd           <= next_mem_rd;
      mem_wr           <= next_mem_wr;
      mem_wdata        <= next_mem_wdata;
      xchg_req         <= next_xchg_req;
      xchg_addr        <= next_xchg_addr;
      xchg_set_monitor <= next_xchg_set_monitor;
      xchg_use_ma      <= next_xchg_use_ma;
      keypoint         <= next_keypoint;
    end
  end

endmodule // pp_exec
`default_nettype wire

/* File: dv/pp_exec_asserts.sv */
// concurrent checks on the execute unit ports
`default_nettype none
module pp_exec_asserts
  import pp_exec_pkg::*;
(
  input wire logic              clk,
  input wire logic              rst_n,
  input wire logic              start,
  input wire logic [OP_W-1:0]   opcode,
  input wire logic [D_W-1:0]    d_field,
  input wire logic [WORD_W-1:0] p_addr,
  input wire logic              cp_monitor_mode,
  input wire logic              busy,
  input wire logic              done,
  input wire logic [ACC_W-1:0]  acc,
  input wire logic [R_W-1:0]    r_reg,
  input wire logic              acc_zero,
  input wire logic              acc_negative,
  input wire logic [WORD_W-1:0] mem_addr,
  input wire logic              mem_rd,
  input wire logic              mem_wr,
  input wire logic [WORD_W-1:0] mem_wdata,
  input wire logic              xchg_req,
  input wire logic [CM_W-1:0]   xchg_addr,
  input wire logic              xchg_set_monitor,
  input wire logic              xchg_use_ma,
  input wire logic              keypoint
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // two halves of the relocation store, low part first
  sequence s_wr_lo;
    mem_wr && mem_addr == {6'h00, $past(d_field)} && mem_wdata == {2'h0, r_reg[9:0]};
  endsequence
  sequence s_wr_hi;
    mem_wr && mem_addr == $past(mem_addr) + 12'h001 && mem_wdata == r_reg[21:10];
  endsequence
  property p_const_fetch;
    start && !busy && opcode == OP_LOAD_CONSTANT |=> mem_rd && mem_addr == $past(p_addr) + 12'h001;
  endproperty
  property p_direct_addr;
    start && !busy && opcode[5:3] == 3'h3 |=> mem_rd && mem_addr == {6'h00, $past(d_field)};
  endproperty
  property p_store_r;
    start && !busy && opcode == OP_STORE_RELOC && d_field != D_ZERO |=> s_wr_lo ##1 s_wr_hi ##0 done;
  endproperty
  property p_reloc_pass;
    start && !busy && (opcode == OP_LOAD_RELOC || opcode == OP_STORE_RELOC) && d_field == D_ZERO
      |=> done && !mem_wr && $stable(r_reg);
  endproperty
  property p_xchg_plain;
    start && !busy && opcode == OP_EXCHANGE && d_field == D_EXCHANGE_UNCONDITIONAL
      |=> xchg_req && !xchg_set_monitor && !xchg_use_ma;
  endproperty
  property p_xchg_addr;
    xchg_req |-> xchg_addr == (acc[SIGN_BIT] ? {r_reg, R_PAD} + CM_W'(acc[16:0]) : CM_W'(acc));
  endproperty
  // monitor mode held steady long enough to pass the synchroniser
  property p_mon_pass;
    cp_monitor_mode [*4] ##0 (start && !busy && opcode == OP_EXCHANGE && d_field[5:3] != 3'h0)
      |=> done && !xchg_req;
  endproperty
  property p_mon_set;
    (!cp_monitor_mode) [*4] ##0 (start && !busy && opcode == OP_EXCHANGE
      && (d_field == D_EXCHANGE_MONITOR || d_field == D_EXCHANGE_TO_MONITOR_ADDRESS))
      |=> xchg_req && xchg_set_monitor
      && xchg_use_ma == ($past(d_field) == D_EXCHANGE_TO_MONITOR_ADDRESS);
  endproperty
  property p_stall;
    xchg_req |-> busy && !done;
  endproperty
  property p_kp;
    keypoint |-> $past(start && !busy && opcode == OP_KEYPOINT) && $stable(acc) && $stable(r_reg)
      ##1 !keypoint;
  endproperty
  property p_sign;
    acc_zero == (acc == 18'h00000) && acc_negative == acc[SIGN_BIT];
  endproperty
  a_const_fetch: assert property (p_const_fetch) else $error("constant fetch address");
  a_direct_addr: assert property (p_direct_addr) else $error("direct operand address");
  a_store_r: assert property (p_store_r) else $error("relocation store pair");
  a_reloc_pass: assert property (p_reloc_pass) else $error("relocation pass");
  a_xchg_plain: assert property (p_xchg_plain) else $error("plain exchange flags");
  a_xchg_addr: assert property (p_xchg_addr) else $error("exchange address");
  a_mon_pass: assert property (p_mon_pass) else $error("monitor exchange pass");
  a_mon_set: assert property (p_mon_set) else $error("monitor exchange flags");
  a_stall: assert property (p_stall) else $error("no completion during exchange");
  a_kp: assert property (p_kp) else $error("keypoint pulse");
  a_sign: assert property (p_sign) else $error("zero and sign status");
endmodule // pp_exec_asserts
bind pp_exec pp_exec_asserts u_chk (.clk, .rst_n, .start, .opcode, .d_field, .p_addr,
  .cp_monitor_mode, .busy, .done, .acc, .r_reg, .acc_zero, .acc_negative, .mem_addr, .mem_rd,
  .mem_wr, .mem_wdata, .xchg_req, .xchg_addr, .xchg_set_monitor, .xchg_use_ma, .keypoint);
`default_nettype wire

/* File: dv/pp_far_model.sv */
// memory and central-processor exchange responder facing the execute unit
`default_nettype none
module pp_far_model
  import pp_exec_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic              slow,
  input  wire logic [WORD_W-1:0] mem_addr,
  input  wire logic              mem_rd,
  input  wire logic              mem_wr,
  input  wire logic [WORD_W-1:0] mem_wdata,
  output var  logic [WORD_W-1:0] mem_rdata,
  input  wire logic              xchg_req,
  output var  logic              xchg_done
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [WORD_W-1:0] mem [4096];
  logic [2:0]        cnt;
  // data stands in the cycle mem_rd does; idle shows the inverse so stale words never look valid
  always_comb mem_rdata = mem_rd ? mem[mem_addr] : ~mem[mem_addr];
  always @(posedge clk) begin
    if (mem_wr) mem[mem_addr] <= mem_wdata;
  end
  // four-phase acknowledge, quick or slow
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= 3'h0;
      xchg_done <= 1'b0;
    end else if (!xchg_req) begin
      cnt <= 3'h0;
      xchg_done <= 1'b0;
    end else if (cnt == (slow ? 3'h5 : 3'h1)) xchg_done <= 1'b1;
    else cnt <= cnt + 3'h1;
  end
endmodule // pp_far_model
`default_nettype wire

/* File: dv/tb_pp_instruction_execute_20_to_51.sv */
// self-checking bench for the execute unit with memory and exchange partner
`default_nettype none
module tb_pp_instruction_execute_20_to_51;
  import pp_exec_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, rst_n = 0, start = 0, mon = 0, slow = 0, busy, done, xreq, xdone, xmon, xma;
  logic mrd, mwr, az, an, kp;
  logic [5:0] op = 0, d = 0, ro, rd;
  logic [11:0] p = 0, maddr, mwd, mrdata, sh [4096], wa, rp;
  logic [17:0] acc, a_m;
  logic [21:0] r_reg, r_m;
  logic [27:0] xaddr, xe;
  bit wr_exp;
  int n_errors = 0, n_compared = 0, kp_cnt = 0, i, n, x;
  pp_exec uut (.clk, .rst_n, .start, .opcode(op), .d_field(d), .p_addr(p), .mem_rdata(mrdata),
    .cp_monitor_mode(mon), .xchg_done(xdone), .busy, .done, .acc, .r_reg, .acc_zero(az),
    .acc_negative(an), .mem_addr(maddr), .mem_rd(mrd), .mem_wr(mwr), .mem_wdata(mwd),
    .xchg_req(xreq), .xchg_addr(xaddr), .xchg_set_monitor(xmon), .xchg_use_ma(xma),
    .keypoint(kp));
  pp_far_model mdl (.clk, .rst_n, .slow, .mem_addr(maddr), .mem_rd(mrd), .mem_wr(mwr),
    .mem_wdata(mwd), .mem_rdata(mrdata), .xchg_req(xreq), .xchg_done(xdone));
  initial forever #20 clk = ~clk;
  always @(posedge clk) if (kp === 1'b1) kp_cnt++;
  // ones' complement sum, end-around carry
  function automatic logic [17:0] oadd(logic [17:0] a, logic [17:0] b);
    logic [18:0] s;
    s = a + b;
    return s[17:0] + 18'(s[18]);
  endfunction
  task automatic chk(string nm, logic [27:0] e, logic [27:0] v);
    n_compared++;
    if (e !== v) begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, e, v);
    end
  endtask
  // expected accumulator and memory for the data-path opcodes
  task automatic model(logic [5:0] o, logic [5:0] dd, logic [11:0] pp);
    logic [11:0] w, ad;
    logic [17:0] k;
    k = {dd, sh[pp+12'h001]};
    wr_exp = 0;
    if (o[5:3] == 3'h2) begin
      case (o[1:0])
        2'h0: a_m = k;
        2'h1: a_m = oadd(a_m, k);
        2'h2: a_m = a_m & k;
        default: a_m = a_m ^ k;
      endcase
    end else begin
      if (o[5:3] == 3'h3) ad = {6'h00, dd};
      else if (o[5:3] == 3'h4) ad = sh[{6'h00, dd}];
      else ad = sh[pp+12'h001] + (dd == 0 ? 12'h000 : sh[{6'h00, dd}]);
      w = sh[ad];
      case (o[2:0])
        3'h0: a_m = {6'h00, w};
        3'h1, 3'h5: a_m = oadd(a_m, {6'h00, w});
        3'h2: a_m = oadd(a_m, ~{6'h00, w});
        3'h3: a_m[11:0] = a_m[11:0] ^ w;
        3'h6: a_m = oadd({6'h00, w}, 18'h00001);
        3'h7: a_m = oadd({6'h00, w}, 18'h3FFFE);
        default: ;
      endcase
      if (o[2]) begin
        sh[ad] = a_m[11:0];
        wr_exp = 1;
        wa = ad;
      end
    end
  endtask
  // one instruction: start pulse, then bounded wait for done
  task automatic run(logic [5:0] o, logic [5:0] dd, logic [11:0] pp);
    int j;
    @(posedge clk);
    start <= 1;
    op <= o;
    d <= dd;
    p <= pp;
    @(posedge clk);
    start <= 0;
    for (j = 0; j < 100; j++) begin
      #1;
      if (done === 1'b1) break;
      @(posedge clk);
    end
    chk("done", 1, done);
    @(posedge clk); // memory write of the last cycle lands here
    #1;
  endtask
  task automatic summarize();
    if (n_errors == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // watchdog far beyond the expected thousand or so cycles
  initial begin
    #800000;
    n_errors++;
    summarize();
  end
  // main sequence
  initial begin
    void'($urandom(36474));
    for (i = 0; i < 4096; i++) begin
      sh[i] = 12'($urandom);
      mdl.mem[i] = sh[i];
    end
    repeat (8) @(posedge clk);
    rst_n <= 1;
    a_m = 0;
    r_m = 0;
    for (n = 0; n < 200; n++) begin
      x = $urandom % 22;
      ro = x < 4 ? 6'(16 + x) : 6'(20 + x);
      rd = 6'($urandom);
      rp = 12'($urandom);
      model(ro, rd, rp);
      run(ro, rd, rp);
      chk("acc", a_m, acc);
      if (wr_exp) chk("mem", sh[wa], mdl.mem[wa]);
    end
    sh[12'h101] = 12'hFFF;
    mdl.mem[12'h101] = 12'hFFF;
    model(6'h10, 6'h3F, 12'h100);
    run(6'h10, 6'h3F, 12'h100);
    chk("acc_zero", 0, az);
    chk("acc_negative", 1, an);
    r_m = {sh[12'h040], sh[12'h03F][9:0]};
    run(6'h14, 6'h3F, 0);
    chk("r_reg", r_m, r_reg);
    run(6'h15, 6'h05, 0);
    chk("mem_lo", {2'h0, r_m[9:0]}, mdl.mem[5]);
    chk("mem_hi", r_m[21:10], mdl.mem[6]);
    run(6'h14, 0, 0);
    run(6'h15, 0, 0);
    chk("r_pass", r_m, r_reg);
    chk("mem_pass", sh[0], mdl.mem[0]);
    mon <= 1;
    repeat (4) @(posedge clk);
    run(6'h16, 6'h08, 0);
    run(6'h16, 6'h10, 0);
    mon <= 0;
    repeat (4) @(posedge clk);
    xe = a_m[17] ? {r_m, 6'h00} + 28'(a_m[16:0]) : 28'(a_m);
    for (i = 0; i < 3; i++) begin
      slow <= i[0];
      run(6'h16, 6'(i * 8), 0);
      chk("xchg_addr", xe, xaddr);
      chk("xchg_set_monitor", i > 0, xmon);
      chk("xchg_use_ma", i == 2, xma);
    end
    kp_cnt = 0;
    run(6'h17, 0, 0);
    chk("keypoint", 1, kp_cnt);
    chk("acc_kp", a_m, acc);
    summarize();
  end
endmodule // tb_pp_instruction_execute_20_to_51
`default_nettype wire
